// file: ucsb_pkg.sv
// Purpose: Constants for the serial status and control bank.
// Assumes: Wishbone word index = byte address / 4.
// Notes: Offsets below are register indexes.
package ucsb_pkg;
	localparam int        ADR_W       = 5;
	localparam int        IDX_W       = 3;
	localparam int        DAT_W       = 32;
	localparam int        FIFO_W      = 11;
	localparam logic [2:0] IDX_RXDATAL = 3'h0;
	localparam logic [2:0] IDX_RXDATAH = 3'h1;
	localparam logic [2:0] IDX_TRANSMIT_LOW_BYTE = 3'h2;
	localparam logic [2:0] IDX_STATUS  = 3'h4;
	localparam logic [2:0] IDX_INTERRUPT_AND_LINE_CONTROL   = 3'h5;
	localparam logic [2:0] IDX_ENABLE_AND_RECEIVE_MODE_CONTROL   = 3'h6;
	// Status bit positions.
	localparam int ST_RXC = 7;
	localparam int ST_TXC = 6;
	localparam int ST_DRE = 5;
	localparam int ST_RXS = 4;
	localparam int ST_ISF = 3;
	localparam int ST_BDF = 1;
	localparam int ST_WFB = 0;
	// Interrupt and line control bit positions.
	localparam int CA_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
	localparam int CA_TRANSMIT_COMPLETE_IRQ_ENABLE = 6;
	localparam int CA_DATA_EMPTY_IRQ_ENABLE = 5;
	localparam int CA_START_FRAME_IRQ_ENABLE = 4;
	localparam int CA_LOOPBACK_ENABLE  = 3;
	localparam int CA_AUTOBAUD_ERROR_IRQ_ENABLE = 2;
	localparam int CA_LDM   = 0;
	// Enable and receive mode bit positions.
	localparam int CB_RECEIVER_ENABLE  = 7;
	localparam int CB_TRANSMITTER_ENABLE  = 6;
	localparam int CB_START_FRAME_DETECT_ENABLE = 4;
	localparam int CB_RXM   = 1;
	localparam logic [7:0] INTERRUPT_AND_LINE_CONTROL_RST = 8'h00;
	localparam logic [7:0] ENABLE_AND_RECEIVE_MODE_CONTROL_RST = 8'h00;
	localparam logic [7:0] ENABLE_AND_RECEIVE_MODE_CONTROL_WMASK = 8'hd6;
	localparam logic [1:0] LDM_OFF = 2'h0;
	localparam logic [1:0] LDM_EXT = 2'h1;
	localparam logic [1:0] LDM_INT = 2'h2;
	localparam logic [1:0] RXM_NORMAL = 2'h0;
	localparam logic [1:0] RXM_DOUBLE_SPEED_MODE  = 2'h1;
	localparam logic [1:0] RXM_GENERIC_AUTOBAUD_MODE = 2'h2;
	localparam logic [1:0] RXM_LIN_CONSTRAINED_AUTOBAUD_MODE = 2'h3;
	localparam logic [7:0] SYNC_CHAR = 8'h55;
	localparam logic [3:0] BREAK_BITS = 4'hb;
	typedef enum logic [1:0] {UCSB_TX_OFF, UCSB_TX_ON, UCSB_TX_DRAIN} ucsb_tx_t;
endpackage : ucsb_pkg

// file: ucsb_line_edge.sv
// Purpose: Edge finder on the receive line.
// Assumes: Line already synchronous to clk_i.
// Notes: Rise is reported only after a low level was seen.
`timescale 1ns/1ps
module ucsb_line_edge
	import ucsb_pkg::*;
(
	input  wire logic clk_i,   // Clock.
	input  wire logic rst_i,   // Synchronous reset.
	input  wire logic line_i,  // Receive line.
	output logic      fall_o,  // Idle-high to start-low edge.
	output logic      rise_o   // Low-to-high edge.
);
	logic prev;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			prev <= 1'b1;
		else
			prev <= line_i;
	end

	assign fall_o = prev & ~line_i;
	assign rise_o = ~prev & line_i;

	a_fall_edge: assert property (@(posedge clk_i) disable iff (rst_i)
		fall_o |-> $past(line_i) && !line_i) else $error("fall without edge");
endmodule : ucsb_line_edge

// file: ucsb_rx_fifo.sv
// Purpose: Two-entry receive buffer.
// Assumes: Push is dropped when full; flush wins over push.
// Notes: Entry holds data plus frame, overflow and parity flags.
`timescale 1ns/1ps
module ucsb_rx_fifo
	import ucsb_pkg::*;
(
	input  wire logic              clk_i,   // Clock.
	input  wire logic              rst_i,   // Synchronous reset.
	input  wire logic              flush_i, // Drop all entries.
	input  wire logic              push_i,  // Write one entry.
	input  wire logic [FIFO_W-1:0] data_i,  // Entry to write.
	input  wire logic              pop_i,   // Discard head entry.
	output logic      [FIFO_W-1:0] head_o,  // Head entry.
	output logic      [1:0]        count_o  // Entries held.
);
	logic [FIFO_W-1:0] mem [2];
	logic              rd;
	logic              wr;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || flush_i)
		begin
			rd      <= 1'b0;
			wr      <= 1'b0;
			count_o <= 2'h0;
		end
		else
		begin
			if (push_i && count_o != 2'h2)
			begin
				mem[wr] <= data_i;
				wr      <= ~wr;
			end
			if (pop_i && count_o != 2'h0)
				rd <= ~rd;
			count_o <= count_o + 2'((push_i && count_o != 2'h2) ? 1 : 0)
				- 2'((pop_i && count_o != 2'h0) ? 1 : 0);
		end
	end

	assign head_o = (count_o == 2'h0) ? '0 : mem[rd];

	a_fifo_flush: assert property (@(posedge clk_i) disable iff (rst_i)
		flush_i |=> count_o == 2'h0) else $error("flush left entries");
endmodule : ucsb_rx_fifo

// file: ucsb_bank.sv
// Purpose: Status, interrupt and enable control of a serial transceiver.
// Assumes: Receiver, transmitter shifter and baud logic sit outside.
// Notes: Classic Wishbone slave, ack one cycle after request.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module ucsb_bank
	import ucsb_pkg::*;
(
	input  wire logic             clk_i,        // Clock, 200 MHz.
	input  wire logic             rst_i,        // Synchronous reset.
	input  wire logic             cyc_i,        // Wishbone cycle.
	input  wire logic             stb_i,        // Wishbone strobe.
	input  wire logic             we_i,         // Wishbone write.
	input  wire logic [ADR_W-1:0] adr_i,        // Byte address.
	input  wire logic [3:0]       sel_i,        // Byte selects.
	input  wire logic [DAT_W-1:0] dat_i,        // Write data.
	output logic      [DAT_W-1:0] dat_o,        // Read data.
	output logic                  ack_o,        // Acknowledge.
	input  wire logic             rxd_i,        // Receive pin.
	input  wire logic             txd_core_i,   // Serial out of shifter.
	output logic                  rxd_core_o,   // Serial in to receiver.
	output logic                  txd_o,        // Transmit pin value.
	output logic                  txd_oe_o,     // Transmit pin drive.
	output logic                  rxd_own_o,    // Receive pin overridden.
	output logic                  te_o,         // External driver enable.
	input  wire logic             baud_tick_i,  // One pulse per bit time.
	input  wire logic             rx_valid_i,   // Character received.
	input  wire logic [7:0]       rx_data_i,    // Received character.
	input  wire logic [2:0]       rx_err_i,     // Frame, overflow, parity.
	input  wire logic             sync_done_i,  // Sync character ended.
	input  wire logic             sync_bad_i,   // Sync timing invalid.
	input  wire logic [7:0]       sync_char_i,  // Sync character value.
	input  wire logic             tx_busy_i,    // Shifter holds a frame.
	input  wire logic             tx_done_i,    // Frame fully shifted.
	output logic                  tx_load_o,    // Move buffer to shifter.
	output logic      [7:0]       tx_data_o,    // Character to shifter.
	output logic                  rx_enable_o,  // Receiver enabled.
	output logic                  tx_enable_o,  // Transmitter active.
	output logic      [1:0]       rx_mode_o,    // Receiver mode.
	output logic                  ab_reset_o,   // Auto-baud logic reset.
	output logic                  fsm_idle_o,   // Return to idle pulse.
	input  wire logic             sleep_idle_i, // System in idle sleep.
	input  wire logic             sleep_stby_i, // System in standby.
	output logic                  wake_o,       // Wake request pulse.
	input  wire logic             txc_ack_i,    // Transmit vector taken.
	output logic                  rx_irq_o,     // Receive vector request.
	output logic                  txc_irq_o,    // Transmit done request.
	output logic                  dre_irq_o     // Buffer empty request.
);
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [7:0]       ctrl_a;
	logic [7:0]       ctrl_b;
	logic             f_txc;
	logic             f_dre;
	logic             f_rxs;
	logic             f_isf;
	logic             f_bdf;
	logic [7:0]       tx_buf;
	logic [FIFO_W-1:0] rx_head;
	logic [1:0]       rx_count;
	logic             req;
	logic             wr;
	logic             rd;
	logic [IDX_W-1:0] idx;
	logic [7:0]       wbyte;
	logic             fall;
	logic             rise;
	logic             autobaud;
	logic             break_arm;
	logic             wfb_arm;
	logic [3:0]       low_bits;
	ucsb_tx_t         tx_state;

	function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] b);
		hit = (a == b);
	endfunction : hit

	assign req   = cyc_i & stb_i;
	assign idx   = adr_i[ADR_W-1:2];
	assign wbyte = dat_i[7:0];
	// Writes and pops act on the edge at which the master sees ack.
	assign wr    = req & ack_o & we_i & sel_i[0];
	assign rd    = req & ack_o & ~we_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= req & ~ack_o;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= '0;
		else if (req & ~ack_o & ~we_i)
		begin
			dat_o <= '0;
			case (idx)
				IDX_RXDATAL: dat_o[7:0] <= rx_head[7:0];
				IDX_RXDATAH: dat_o[7:0] <= {(rx_count != 2'h0), rx_head[9], 3'h0,
					rx_head[8], rx_head[10], 1'b0};
				IDX_STATUS:  dat_o[7:0] <= {(rx_count != 2'h0), f_txc, f_dre,
					f_rxs & ctrl_b[CB_START_FRAME_DETECT_ENABLE], f_isf, 1'b0, f_bdf, 1'b0};
				IDX_INTERRUPT_AND_LINE_CONTROL:   dat_o[7:0] <= ctrl_a;
				IDX_ENABLE_AND_RECEIVE_MODE_CONTROL:   dat_o[7:0] <= ctrl_b;
				default:     dat_o <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_a <= INTERRUPT_AND_LINE_CONTROL_RST;
			ctrl_b <= ENABLE_AND_RECEIVE_MODE_CONTROL_RST;
		end
		else if (wr && hit(idx, IDX_INTERRUPT_AND_LINE_CONTROL))
			ctrl_a <= wbyte;
		else if (wr && hit(idx, IDX_ENABLE_AND_RECEIVE_MODE_CONTROL))
			ctrl_b <= wbyte & ENABLE_AND_RECEIVE_MODE_CONTROL_WMASK;
	end

	assign rx_mode_o   = ctrl_b[CB_RXM+:2];
	assign rx_enable_o = ctrl_b[CB_RECEIVER_ENABLE];
	assign rxd_own_o   = ctrl_b[CB_RECEIVER_ENABLE];
	assign autobaud    = (rx_mode_o == RXM_GENERIC_AUTOBAUD_MODE) || (rx_mode_o == RXM_LIN_CONSTRAINED_AUTOBAUD_MODE);
	// Held while the receiver is off in an auto-baud mode so no half-measured sync survives.
	assign ab_reset_o  = autobaud & ~ctrl_b[CB_RECEIVER_ENABLE];

	// ------------------------------------------------------------
	// Receive path
	// ------------------------------------------------------------
	assign rxd_core_o = ctrl_a[CA_LOOPBACK_ENABLE] ? txd_core_i : rxd_i;

	ucsb_line_edge u_edge (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.line_i (rxd_core_o),
		.fall_o (fall),
		.rise_o (rise)
	);

	ucsb_rx_fifo u_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (~ctrl_b[CB_RECEIVER_ENABLE]),
		.push_i  (rx_valid_i),
		.data_i  ({rx_err_i, rx_data_i}),
		.pop_i   (rd && hit(idx, IDX_RXDATAL)),
		.head_o  (rx_head),
		.count_o (rx_count)
	);

	// ------------------------------------------------------------
	// Break and sync flags
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !autobaud || !ctrl_b[CB_RECEIVER_ENABLE])
		begin
			low_bits  <= 4'h0;
			break_arm <= 1'b0;
			wfb_arm   <= 1'b0;
		end
		else
		begin
			if (wr && hit(idx, IDX_STATUS) && wbyte[ST_WFB])
				wfb_arm <= 1'b1;
			else if (wfb_arm && rise)
				wfb_arm <= 1'b0;
			if (baud_tick_i)
				low_bits <= rxd_core_o ? 4'h0 :
					(low_bits == BREAK_BITS ? low_bits : low_bits + 4'h1);
			if ((baud_tick_i && !rxd_core_o && low_bits == BREAK_BITS - 4'h1)
				|| (wfb_arm && rise))
				break_arm <= 1'b1;
			else if (sync_done_i)
				break_arm <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			f_bdf <= 1'b0;
		else if (autobaud && break_arm && sync_done_i && !sync_bad_i)
			f_bdf <= 1'b1;
		else if (rx_valid_i || (wr && hit(idx, IDX_STATUS) && wbyte[ST_BDF]))
			f_bdf <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			f_isf <= 1'b0;
		else if (autobaud && sync_done_i && (sync_bad_i
			|| (rx_mode_o == RXM_LIN_CONSTRAINED_AUTOBAUD_MODE && sync_char_i != SYNC_CHAR)))
			f_isf <= 1'b1;
		else if (wr && hit(idx, IDX_STATUS) && wbyte[ST_ISF])
			f_isf <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fsm_idle_o <= 1'b0;
		else
			fsm_idle_o <= wr && hit(idx, IDX_STATUS) && wbyte[ST_ISF];
	end

	// ------------------------------------------------------------
	// Start frame detection
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			f_rxs <= 1'b0;
		else if (ctrl_b[CB_START_FRAME_DETECT_ENABLE] && sleep_stby_i && fall)
			f_rxs <= 1'b1;
		else if (wr && hit(idx, IDX_STATUS) && wbyte[ST_RXS])
			f_rxs <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_o <= 1'b0;
		else
			wake_o <= ctrl_b[CB_START_FRAME_DETECT_ENABLE] & (sleep_idle_i | sleep_stby_i) & fall;
	end

	// ------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			f_dre  <= 1'b1;
			tx_buf <= 8'h00;
		end
		else if (wr && hit(idx, IDX_TRANSMIT_LOW_BYTE) && f_dre)
		begin
			tx_buf <= wbyte;
			f_dre  <= 1'b0;
		end
		else if (tx_load_o)
			f_dre <= 1'b1;
	end

	// A write while the buffer is full is ignored, as the flag warns.
	assign tx_load_o = !f_dre && tx_state != UCSB_TX_OFF && !tx_busy_i;
	assign tx_data_o = tx_buf;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_state <= UCSB_TX_OFF;
		else
		begin
			case (tx_state)
				UCSB_TX_OFF:
					if (ctrl_b[CB_TRANSMITTER_ENABLE])
						tx_state <= UCSB_TX_ON;
				UCSB_TX_ON:
					if (!ctrl_b[CB_TRANSMITTER_ENABLE])
						tx_state <= UCSB_TX_DRAIN;
				UCSB_TX_DRAIN:
					if (ctrl_b[CB_TRANSMITTER_ENABLE])
						tx_state <= UCSB_TX_ON;
					else if (f_dre && !tx_busy_i)
						tx_state <= UCSB_TX_OFF;
				default:
					tx_state <= UCSB_TX_OFF;
			endcase
		end
	end

	assign tx_enable_o = tx_state != UCSB_TX_OFF;
	assign txd_o       = txd_core_i;

	always_comb
	begin
		txd_oe_o = tx_enable_o;
		te_o     = 1'b0;
		case (ctrl_a[CA_LDM+:2])
			LDM_EXT: te_o = tx_enable_o & tx_busy_i;
			LDM_INT: txd_oe_o = tx_enable_o & tx_busy_i;
			default: te_o = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			f_txc <= 1'b0;
		else if (tx_done_i && f_dre && !tx_load_o)
			f_txc <= 1'b1;
		else if (txc_ack_i || (wr && hit(idx, IDX_STATUS) && wbyte[ST_TXC]))
			f_txc <= 1'b0;
	end

	// ------------------------------------------------------------
	// Interrupt requests
	// ------------------------------------------------------------
	assign txc_irq_o = f_txc & ctrl_a[CA_TRANSMIT_COMPLETE_IRQ_ENABLE];
	assign dre_irq_o = f_dre & ctrl_a[CA_DATA_EMPTY_IRQ_ENABLE];
	assign rx_irq_o  = ((rx_count != 2'h0) & ctrl_a[CA_RECEIVE_COMPLETE_IRQ_ENABLE])
		| (f_rxs & ctrl_b[CB_START_FRAME_DETECT_ENABLE] & ctrl_a[CA_START_FRAME_IRQ_ENABLE])
		| (f_isf & ctrl_a[CA_AUTOBAUD_ERROR_IRQ_ENABLE]);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_rxc_flush: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(ctrl_b[CB_RECEIVER_ENABLE]) |=> !(rx_irq_o && !f_isf && !f_rxs)) else $error("rx flag kept");
	a_dre_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == IDX_TRANSMIT_LOW_BYTE && f_dre |=> !f_dre) else $error("empty not cleared");
	a_txc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		txc_ack_i && !tx_done_i |=> !f_txc) else $error("done flag not cleared");
	a_txc_set: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(f_txc) |-> $past(tx_done_i) && $past(f_dre)) else $error("done without frame");
	a_rxs_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(f_rxs) |-> $past(sleep_stby_i) && $past(ctrl_b[CB_START_FRAME_DETECT_ENABLE])) else $error("bad start");
	a_isf_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == IDX_STATUS && wbyte[ST_ISF] |=> fsm_idle_o) else $error("no idle pulse");
	a_tx_drain: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_enable_o && !ctrl_b[CB_TRANSMITTER_ENABLE] && (tx_busy_i || !f_dre) |=> tx_enable_o)
		else $error("transmitter stopped early");
	a_pin_release: assert property (@(posedge clk_i) disable iff (rst_i)
		!tx_enable_o |-> !txd_oe_o && !te_o) else $error("pin driven while off");
	a_loopback: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_a[CA_LOOPBACK_ENABLE] |-> rxd_core_o == txd_core_i) else $error("loop-back broken");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held");
endmodule : ucsb_bank

// file: ucsb_far_node.sv
// Purpose: Remote serial node on the receive line.
// Assumes: The line idles high, as a pulled-up serial wire does.
// Notes: One request gives a start edge, a short low, then idle.
`timescale 1ns/1ps
module ucsb_far_node
	import ucsb_pkg::*;
#(
	parameter int LOW_CYC = 4  // Low time in clocks.
)
(
	input  wire logic clk_i,   // Clock.
	input  wire logic rst_i,   // Synchronous reset.
	input  wire logic send_i,  // Start one low pulse.
	output logic      line_o   // Receive line.
);
	// ----------------------------------------
	// Line driver
	// ----------------------------------------
	int cnt;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt <= 0;
		else if (send_i)
			cnt <= LOW_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end

	// The low and rise give both a start edge and a low-to-high edge.
	assign line_o = (cnt == 0);
endmodule : ucsb_far_node

// file: ucsb_bank_tb.sv
// Purpose: Self-checking bench for the serial status and control bank.
// Assumes: Wishbone slave acks one cycle after a request.
// Notes: Shifter and receiver sides are driven by hand.
`timescale 1ns/1ps
module ucsb_bank_tb;
	import ucsb_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic             clk_i, rst_i, cyc_i, stb_i, we_i, rxd_i, txd_core_i, baud_tick_i;
	logic             rx_valid_i, sync_done_i, sync_bad_i, tx_busy_i, tx_done_i;
	logic             sleep_idle_i, sleep_stby_i, txc_ack_i, send;
	logic [ADR_W-1:0] adr_i;
	logic [3:0]       sel_i;
	logic [DAT_W-1:0] dat_i, dat_o;
	logic [7:0]       rx_data_i, sync_char_i, tx_data_o, q;
	logic [2:0]       rx_err_i;
	logic [1:0]       rx_mode_o;
	logic             ack_o, rxd_core_o, txd_o, txd_oe_o, rxd_own_o, te_o, tx_load_o;
	logic             rx_enable_o, tx_enable_o, ab_reset_o, fsm_idle_o, wake_o;
	logic             rx_irq_o, txc_irq_o, dre_irq_o;
	int               fail_count, samples_checked, n_wake, n_idle, n_load;

	ucsb_bank u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .rxd_i, .txd_core_i, .rxd_core_o, .txd_o, .txd_oe_o, .rxd_own_o,
		.te_o, .baud_tick_i, .rx_valid_i, .rx_data_i, .rx_err_i, .sync_done_i,
		.sync_bad_i, .sync_char_i, .tx_busy_i, .tx_done_i, .tx_load_o, .tx_data_o,
		.rx_enable_o, .tx_enable_o, .rx_mode_o, .ab_reset_o, .fsm_idle_o,
		.sleep_idle_i, .sleep_stby_i, .wake_o, .txc_ack_i, .rx_irq_o, .txc_irq_o,
		.dre_irq_o);
	ucsb_far_node u_far (.clk_i, .rst_i, .send_i(send), .line_o(rxd_i));

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Pulses are counted at the falling edge, where they are settled.
	always @(negedge clk_i)
	begin
		n_wake += (wake_o === 1'b1);
		n_idle += (fsm_idle_o === 1'b1);
		n_load += (tx_load_o === 1'b1);
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		n = 0;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
		begin
			fail_count++;
			report_and_stop();
		end
		// Read data is taken at the edge at which ack is sampled high.
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(negedge clk_i);
	endtask : wb

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(q, e);
	endtask : rd

	task automatic push(input logic [7:0] d);
		@(posedge clk_i);
		rx_data_i <= d;
		rx_valid_i <= 1'b1;
		@(posedge clk_i);
		rx_valid_i <= 1'b0;
		@(negedge clk_i);
	endtask : push

	task automatic sync(input logic [7:0] c);
		@(posedge clk_i);
		sync_char_i <= c;
		sync_done_i <= 1'b1;
		@(posedge clk_i);
		sync_done_i <= 1'b0;
		@(negedge clk_i);
	endtask : sync

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(5'h10, 8'h20);
		rd(5'h14, 8'h00);
		rd(5'h18, 8'h00);
		rd(5'h1c, 8'h00);
		wr(5'h18, 8'hff);
		rd(5'h18, 8'hd6);
		wr(5'h18, 8'h00);
	endtask : t_reset

	// Every enable-register write sets TXEN, so the transmitter stays on; the shifter stays busy so te_o follows the external mode.
	task automatic t_modes();
		@(posedge clk_i);
		tx_busy_i <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			wr(5'h18, {5'h8, m[1:0], 1'b0});
			chk(rx_mode_o, m[1:0]);
			chk(ab_reset_o, m[1]);
			wr(5'h14, {6'h0, m[1:0]});
			chk(te_o, m == 1);
		end
		wr(5'h14, 8'h00);
	endtask : t_modes

	task automatic t_tx();
		wr(5'h18, 8'h40);
		wr(5'h08, 8'h3c);
		rd(5'h10, 8'h00);
		wr(5'h08, 8'h77);
		wr(5'h18, 8'h00);
		chk(tx_enable_o, 1'b1);
		@(posedge clk_i);
		tx_busy_i <= 1'b0;
		for (int k = 0; k < 20 && n_load == 0; k++)
			@(negedge clk_i);
		chk(n_load, 8'h01);
		@(posedge clk_i);
		tx_busy_i <= 1'b1;
		@(posedge clk_i);
		tx_busy_i <= 1'b0;
		tx_done_i <= 1'b1;
		@(posedge clk_i);
		tx_done_i <= 1'b0;
		repeat (2) @(negedge clk_i);
		chk(tx_data_o, 8'h3c);
		chk(tx_enable_o, 1'b0);
		chk(txd_oe_o, 1'b0);
		rd(5'h10, 8'h60);
		wr(5'h14, 8'h60);
		chk({txc_irq_o, dre_irq_o}, 8'h03);
		@(posedge clk_i);
		txc_ack_i <= 1'b1;
		@(posedge clk_i);
		txc_ack_i <= 1'b0;
		@(negedge clk_i);
		chk(txc_irq_o, 1'b0);
		wr(5'h14, 8'h00);
	endtask : t_tx

	task automatic t_rx();
		wr(5'h18, 8'h80);
		chk(rxd_own_o, 1'b1);
		wr(5'h14, 8'h80);
		push(8'ha5);
		rd(5'h10, 8'ha0);
		chk(rx_irq_o, 1'b1);
		rd(5'h00, 8'ha5);
		rd(5'h10, 8'h20);
		push(8'h5a);
		wr(5'h18, 8'h00);
		rd(5'h10, 8'h20);
		chk(rx_irq_o, 1'b0);
	endtask : t_rx

	task automatic t_start();
		wr(5'h18, 8'h90);
		wr(5'h14, 8'h10);
		@(posedge clk_i);
		sleep_stby_i <= 1'b1;
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		for (int k = 0; k < 20 && n_wake == 0; k++)
			@(negedge clk_i);
		chk(n_wake, 8'h01);
		rd(5'h10, 8'h30);
		chk(rx_irq_o, 1'b1);
		wr(5'h10, 8'h10);
		rd(5'h10, 8'h20);
	endtask : t_start

	task automatic t_sync();
		wr(5'h18, 8'h86);
		wr(5'h14, 8'h04);
		sync(8'h54);
		rd(5'h10, 8'h28);
		chk(rx_irq_o, 1'b1);
		wr(5'h10, 8'h08);
		rd(5'h10, 8'h20);
		chk(n_idle, 8'h01);
		wr(5'h10, 8'h01);
		rd(5'h10, 8'h20);
		@(posedge clk_i);
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		repeat (8) @(posedge clk_i);
		sync(8'h55);
		rd(5'h10, 8'h22);
		push(8'h11);
		rd(5'h10, 8'ha0);
		wr(5'h18, 8'h00);
	endtask : t_sync

	task automatic t_loop();
		wr(5'h14, 8'h08);
		@(posedge clk_i);
		txd_core_i <= 1'b0;
		@(negedge clk_i);
		chk({rxd_core_o, txd_o}, 8'h00);
		@(posedge clk_i);
		txd_core_i <= 1'b1;
		wr(5'h14, 8'h00);
		chk(rxd_core_o, 1'b1);
		@(posedge clk_i);
		txd_core_i <= 1'b0;
		@(negedge clk_i);
		chk(rxd_core_o, 1'b1);
		@(posedge clk_i);
		txd_core_i <= 1'b1;
	endtask : t_loop

	// Loop-back holds the line low for counted bit times; first pass has bad sync timing.
	task automatic t_break();
		wr(5'h18, 8'h84);
		wr(5'h14, 8'h08);
		for (int j = 0; j < 2; j++)
		begin
			@(posedge clk_i);
			baud_tick_i <= 1'b1;
			@(posedge clk_i);
			txd_core_i <= 1'b0;
			repeat (11) @(posedge clk_i);
			baud_tick_i <= 1'b0;
			txd_core_i <= 1'b1;
			sync_bad_i <= (j == 0);
			sync(8'h55);
			rd(5'h10, (j == 0) ? 8'h28 : 8'h22);
			wr(5'h10, 8'h0a);
		end
		wr(5'h14, 8'h00);
		wr(5'h18, 8'h00);
	endtask : t_break

	initial
	begin
		{rst_i, cyc_i, stb_i, we_i, baud_tick_i, rx_valid_i, sync_done_i} = 7'h40;
		{sync_bad_i, tx_busy_i, tx_done_i, sleep_idle_i, sleep_stby_i} = 5'h00;
		{txc_ack_i, send, txd_core_i} = 3'h1;
		{adr_i, sel_i, dat_i, rx_data_i, sync_char_i, rx_err_i} = '0;
		sel_i = 4'h1;
		fail_count = 0;
		samples_checked = 0;
		n_wake = 0;
		n_idle = 0;
		n_load = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_modes();
		t_tx();
		t_rx();
		t_start();
		t_sync();
		t_break();
		t_loop();
		report_and_stop();
	end
endmodule : ucsb_bank_tb
